/* File: core/divider_sync_ctrl.v */
`timescale 1ns/1ns
`default_nettype none
`include "output_clock_source_map.vh"
module divider_sync_ctrl (
  input wire core_clk,
  input wire rst,
  input wire clkEn,
  input wire syncBit,
  input wire [1:0] pairSel,
  output reg dividerHold
);
  reg syncPrev_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syncPrev_q <= 1'b0;
      dividerHold <= 1'b0;
    end else if (clkEn) begin
      syncPrev_q <= syncBit;
      if (pairSel != `OCS_SRC_PLL) begin
        dividerHold <= 1'b0;
      end else if (syncBit && !syncPrev_q) begin
        dividerHold <= 1'b1;
      end else if (!syncBit && syncPrev_q) begin
        dividerHold <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/output_clock_source_map.vh */
// Contract
// - pairs two and three each have a 2-bit source select, reset to PLL
// - select codes: 00 PLL, 01 reference zero, 10 reference one, 11 crystal
// - reserved bits read back unspecified; readers must not rely on them
// - bit 7 resets 0; rising holds dividers, falling releases them together (the code holds only pairs whose select is PLL)
`ifndef OUTPUT_CLOCK_SOURCE_MAP_VH
`define OUTPUT_CLOCK_SOURCE_MAP_VH
`define OCS_IDX_CONTROL 8'h63
`define OCS_IDX_RSVD_A 8'h64
`define OCS_IDX_RSVD_B 8'h65
`define OCS_IDX_RSVD_C 8'h66
`define OCS_IDX_RSVD_D 8'h67
`define OCS_BIT_SYNC 7
`define OCS_PAIR3_HI 5
`define OCS_PAIR3_LO 4
`define OCS_PAIR2_HI 1
`define OCS_PAIR2_LO 0
`define OCS_SRC_PLL 2'h0
`define OCS_SRC_REF0 2'h1
`define OCS_SRC_REF1 2'h2
`define OCS_SRC_XTAL 2'h3
`define OCS_RESET_CONTROL 8'h00
`define OCS_RESET_RSVD 8'h00
`define OCS_RESP_OKAY 2'h0
`define OCS_RESP_SLVERR 2'h2
`endif

/* File: core/output_clock_source_select.v */
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "output_clock_source_map.vh"
module output_clock_source_select (
  input wire core_clk,
  input wire rst,
  input wire clkEn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [1:0] pairTwoSourceSelect,
  output reg [1:0] pairThreeSourceSelect,
  output wire pairTwoDividerHold,
  output wire pairThreeDividerHold
);
  reg [7:0] control_q;
  reg [7:0] rsvd_q [0:3];
  reg [11:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg awHeld_q;
  reg wHeld_q;
  integer i;

  function [2:0] decodeIdx;
    input [11:0] addr;
    begin
      if (addr[11:10] != 2'h0 || addr[1:0] != 2'h0) begin
        decodeIdx = 3'h7;
      end else if (addr[9:2] == `OCS_IDX_CONTROL) begin
        decodeIdx = 3'h4;
      end else if (addr[9:2] >= `OCS_IDX_RSVD_A && addr[9:2] <= `OCS_IDX_RSVD_D) begin
        decodeIdx = {1'b0, addr[3:2]};
      end else begin
        decodeIdx = 3'h7;
      end
    end
  endfunction

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire awGo = awHeld_q || (s_axi_awvalid && s_axi_awready);
  wire wGo = wHeld_q || (s_axi_wvalid && s_axi_wready);
  wire [11:0] wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
  wire [31:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
  wire [3:0] wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
  wire doWrite = awGo && wGo && !s_axi_bvalid;
  wire [2:0] wrIdx = decodeIdx(wrAddr);
  wire [2:0] rdIdx = decodeIdx(s_axi_araddr);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OCS_RESP_OKAY;
      control_q <= `OCS_RESET_CONTROL;
      for (i = 0; i < 4; i = i + 1) begin
        rsvd_q[i] <= `OCS_RESET_RSVD;
      end
    end else if (clkEn) begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrIdx == 3'h7) ? `OCS_RESP_SLVERR : `OCS_RESP_OKAY;
        if (wrStrb[0] && wrIdx == 3'h4) begin
          control_q <= wrData[7:0];
        end else if (wrStrb[0] && wrIdx != 3'h7) begin
          rsvd_q[wrIdx[1:0]] <= wrData[7:0];
        end
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          awHeld_q <= 1'b1;
          awAddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wHeld_q <= 1'b1;
          wData_q <= s_axi_wdata;
          wStrb_q <= s_axi_wstrb;
        end
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `OCS_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (rdIdx == 3'h4) begin
          s_axi_rdata <= {24'h000000, control_q};
          s_axi_rresp <= `OCS_RESP_OKAY;
        end else if (rdIdx != 3'h7) begin
          s_axi_rdata <= {24'h000000, rsvd_q[rdIdx[1:0]]};
          s_axi_rresp <= `OCS_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `OCS_RESP_SLVERR;
        end
      end
    end
  end

  // source code to pair mux setting
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pairTwoSourceSelect <= `OCS_SRC_PLL;
      pairThreeSourceSelect <= `OCS_SRC_PLL;
    end else if (clkEn) begin
      pairTwoSourceSelect <= control_q[`OCS_PAIR2_HI:`OCS_PAIR2_LO];
      pairThreeSourceSelect <= control_q[`OCS_PAIR3_HI:`OCS_PAIR3_LO];
    end
  end

  divider_sync_ctrl pairTwoSync (
    .core_clk(core_clk),
    .rst(rst),
    .clkEn(clkEn),
    .syncBit(control_q[`OCS_BIT_SYNC]),
    .pairSel(control_q[`OCS_PAIR2_HI:`OCS_PAIR2_LO]),
    .dividerHold(pairTwoDividerHold)
  );

  divider_sync_ctrl pairThreeSync (
    .core_clk(core_clk),
    .rst(rst),
    .clkEn(clkEn),
    .syncBit(control_q[`OCS_BIT_SYNC]),
    .pairSel(control_q[`OCS_PAIR3_HI:`OCS_PAIR3_LO]),
    .dividerHold(pairThreeDividerHold)
  );
endmodule
`default_nettype wire

/* File: tb/output_clock_source_select_props.sv */
`timescale 1ns/1ns
`default_nettype none
module output_clock_source_select_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] pairTwoSourceSelect,
  input wire logic [1:0] pairThreeSourceSelect,
  input wire logic pairTwoDividerHold,
  input wire logic pairThreeDividerHold
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sel_after_write_a: assert property (
    $changed({pairThreeSourceSelect, pairTwoSourceSelect}) |-> $past(s_axi_bvalid))
    else $error("select moved without a write");
  hold_two_rise_a: assert property ($rose(pairTwoDividerHold) |-> $past(s_axi_bvalid))
    else $error("pair two hold rose without a write");
  hold_three_rise_a: assert property ($rose(pairThreeDividerHold) |-> $past(s_axi_bvalid))
    else $error("pair three hold rose without a write");
  pll_only_two_a: assert property (pairTwoSourceSelect != 2'h0 |=> !pairTwoDividerHold)
    else $error("pair two held while off pll");
  pll_only_three_a: assert property (pairThreeSourceSelect != 2'h0 |=> !pairThreeDividerHold)
    else $error("pair three held while off pll");
endmodule
bind output_clock_source_select output_clock_source_select_props props_inst (.*);
`default_nettype wire

/* File: tb/output_clock_source_select_test.sv */
`timescale 1ns/1ns
`default_nettype none
module output_clock_source_select_test;
  logic core_clk = 0, rst = 1, clkEn = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid, s_axi_awready, s_axi_wready;
  logic s_axi_arready, s_axi_rvalid, pairTwoDividerHold, pairThreeDividerHold, da, dw, dr, dn;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, pairTwoSourceSelect, pairThreeSourceSelect, r;
  logic [11:0] rows [4] = '{12'h011, 12'h126, 12'h23B, 12'h30C};
  int err_count = 0, check_count = 0, cyc = 0;
  output_clock_source_select output_clock_source_select_inst (.*);
  initial forever #2 core_clk = ~core_clk;
  task stop_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    dn = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    while (!dn) begin
      @(negedge core_clk);
      da = s_axi_awvalid && s_axi_awready;
      dw = s_axi_wvalid && s_axi_wready;
      dr = s_axi_arvalid && s_axi_arready;
      dn = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge core_clk);
      if (da) s_axi_awvalid <= 0;
      if (dw) s_axi_wvalid <= 0;
      if (dr) s_axi_arvalid <= 0;
      if (dn) s_axi_bready <= 0;
      if (dn) s_axi_rready <= 0;
    end
    repeat (2) @(negedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      xfer(1, 12'h18C, rows[i][11:4]);
      chk({pairThreeSourceSelect, pairTwoSourceSelect}, rows[i][3:0]);
      xfer(0, 12'h18C, 8'h00);
      chk(q, rows[i][11:4]);
    end
    @(posedge core_clk);
    rst <= 1;
    repeat (2) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    chk({pairThreeSourceSelect, pairTwoSourceSelect}, 0);
    xfer(0, 12'h18C, 8'h00);
    chk(q, 0);
    xfer(1, 12'h18C, 8'h80);
    chk({pairThreeDividerHold, pairTwoDividerHold}, 2'b11);
    xfer(1, 12'h18C, 8'h81);
    chk({pairThreeDividerHold, pairTwoDividerHold}, 2'b10);
    xfer(1, 12'h18C, 8'h01);
    chk({pairThreeDividerHold, pairTwoDividerHold}, 2'b00);
    xfer(1, 12'h004, 8'h01);
    chk(r, 2'h2);
    xfer(1, 12'h190, 8'h00);
    chk(r, 2'h0);
    xfer(0, 12'h190, 8'h00);
    chk(r, 2'h0);
    stop_test;
  end
endmodule
`default_nettype wire
